// file: hw/usr_defs.svh
// register numbers, widths and reset values for the status register group
// assumes a plain 16-bit register port addressed by register number
// ---------------------------------------------------------------------
// Overview of operation
// R1: eight status words at registers 350 to 357
// R2: system words only with systems cabinet
// R3: bit 15 is most significant bit
// R4: sys1 bits 15-12 cabinet board links
// R5: sys1 bits 11-9 transformer fuses 3,2,1
// R6: sys1 bit7 supply2, bit6 supply1, bit8 spare
// R7: sys1 bits 2-0 cabinet fans 3,2,1
// R8: sys2 bit15 bypass switch fuse, bits 14-7 and 0 spare
// R9: sys2 bits 6-1 remote contacts 6-1
// R10: sys3 rotation cw, ccw, frequency lock
// R11: sys3 bit8 bypass contactor command mismatch
// R12: sys3 bit7 any cabinet board link failed
// R13: sys3 bit6 bypass breaker overcurrent trip
// R14: sys3 bits 1,0 grounding transformer trips
// R15: module A bits 15-13 contactors, 1=closed
// R16: module A bits 12-7 board links
// R17: module A bit6 unload timeout, bit5 lowspeed
// R18: module A bits 4,3,0 controller enables
// R19: module A bits 2,1 static switch status
// R20: module B discharging and transformer fuses
// R21: module B supplies 3-1 and fans 6-1
// R22: bit map fixed to logic revision
// R23: live status, spares zero, writes ignored
// ---------------------------------------------------------------------
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH

`define USR_ADDR_W     16
`define USR_DATA_W     16
`define USR_REG_SYS1   16'h015E
`define USR_REG_SYS2   16'h015F
`define USR_REG_SYS3   16'h0160
`define USR_REG_MOD_A  16'h0161
`define USR_REG_MOD_B  16'h0162
`define USR_REG_MOD_C  16'h0163
`define USR_REG_MOD_D  16'h0164
`define USR_REG_MOD_E  16'h0165
`define USR_RDATA_RST  16'h0000
`define USR_LOGIC_REV  16'h0001

`endif

// file: hw/usr_pkg.sv
// types for the status register group: pin groups and word layouts
// assumes usr_defs.svh supplies the numeric constants
`default_nettype none
package usr_pkg;

  // ---------------------------------------------------------------------
  // pin groups
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] board_link_ok;    // user, io, fan, ac (cab_ac_board_link_ok)
    logic [2:0] xfmr_fuse_ok;     // cab_xfmr3_fuse_ok down to 1
    logic [1:0] supply_good;      // supply 2, cab_supply1_good
    logic [2:0] fan_ok;           // fan 3, 2, 1
    logic       ss_fuse_ok;
    logic [5:0] remote_contact;   // contact 6 down to 1
    logic       bypass_rotation_cw;
    logic       bypass_rotation_ccw;
    logic       freq_lock;
    logic       bypass_breaker_overcurrent_trip;
    logic       grounding_xfmr_overload_trip;
    logic       grounding_xfmr_breaker_trip;
  } usr_cab_pins_t;

  typedef struct packed {
    logic       bypass_contactor_closed;
    logic       output_contactor_closed;
    logic       input_contactor_closed;
    logic [5:0] board_link_ok;    // user, io, fan, dc, ac, genset
    logic       unload_setpoint_timeout;
    logic       low_speed_shutdown;
    logic       rotor_master_ctrl_on;
    logic       ext_sync_cmd;
    logic       static_switch_contactor_state;
    logic       static_switch_fuse_state;
    logic       master_ctrl_on;
    logic       discharging;
    logic [1:0] xfmr_fuse_ok;     // mod_xfmr2_fuse_ok, mod_xfmr1_fuse_ok
    logic [2:0] supply_good;      // mod_supply3_good down to 1
    logic [5:0] fan_ok;           // fan 6 down to 1
  } usr_mod_pins_t;

  // ---------------------------------------------------------------------
  // word layouts, first field is bit 15
  // ---------------------------------------------------------------------
  typedef struct packed {  // R3
    logic [3:0] board_link_ok;    // R4
    logic [2:0] xfmr_fuse_ok;     // R5
    logic       spare_8;
    logic [1:0] supply_good;      // R6
    logic [2:0] spare_5_3;
    logic [2:0] fan_ok;           // R7
  } usr_sys1_t;

  typedef struct packed {
    logic       ss_fuse_ok;       // R8
    logic [7:0] spare_14_7;
    logic [5:0] remote_contact;   // R9
    logic       spare_0;
  } usr_sys2_t;

  typedef struct packed {
    logic       rotation_cw;      // R10
    logic       rotation_ccw;
    logic       freq_lock;
    logic [3:0] spare_12_9;
    logic       contactor_mismatch;
    logic       comm_error;
    logic       breaker_trip;
    logic [3:0] spare_5_2;
    logic       zz_overload_trip;
    logic       zz_breaker_trip;
  } usr_sys3_t;

  typedef struct packed {
    logic [2:0] contactor_closed; // R15
    logic [5:0] board_link_ok;    // R16
    logic       unload_timeout;   // R17
    logic       low_speed_shutdown;
    logic       rotor_master_on;  // R18
    logic       ext_sync_cmd;
    logic       ss_contactor;     // R19
    logic       ss_fuse;
    logic       master_on;
  } usr_mod_a_t;

  typedef struct packed {
    logic [1:0] spare_15_14;
    logic       discharging;      // R20
    logic [1:0] spare_12_11;
    logic [1:0] xfmr_fuse_ok;
    logic [2:0] supply_good;      // R21
    logic [5:0] fan_ok;
  } usr_mod_b_t;

endpackage : usr_pkg
`default_nettype wire

// file: hw/usr_status_regs.sv
// status register group: eight read-only 16-bit words
// assumes status pins are asynchronous and words c to e come from
// logic on clk; the bypass contactor command is also on clk
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "usr_defs.svh"

module usr_status_regs (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      cab_present,
  input  wire usr_pkg::usr_cab_pins_t    cab_pins,
  input  wire usr_pkg::usr_mod_pins_t    mod_pins,
  input  wire logic                      bypass_contactor_cmd,
  input  wire logic [`USR_DATA_W-1:0]    mod_status_c,
  input  wire logic [`USR_DATA_W-1:0]    mod_status_d,
  input  wire logic [`USR_DATA_W-1:0]    mod_status_e,
  input  wire logic [`USR_ADDR_W-1:0]    addr,
  input  wire logic [`USR_DATA_W-1:0]    wdata,
  input  wire logic                      wr_stb,
  input  wire logic                      rd_stb,
  output logic      [`USR_DATA_W-1:0]    rdata,
  output logic      [`USR_DATA_W-1:0]    logic_rev
);

  localparam int CAB_W = $bits(usr_pkg::usr_cab_pins_t);
  localparam int MOD_W = $bits(usr_pkg::usr_mod_pins_t);
  localparam int PIN_W = CAB_W + MOD_W + 1;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  // a change is taken only when stages two and three agree, which also
  // rejects a single-cycle glitch on a contact or relay input
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] stable_reg;

  assign pin_raw = {cab_present, cab_pins, mod_pins};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_reg        <= 1'b0;
          s2_reg        <= 1'b0;
          s3_reg        <= 1'b0;
          stable_reg[gi] <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            stable_reg[gi] <= s3_reg;
          end
        end
      end
    end
  endgenerate

  logic                   cab_ok;
  usr_pkg::usr_cab_pins_t cab_s;
  usr_pkg::usr_mod_pins_t mod_s;

  assign cab_ok = stable_reg[PIN_W-1];
  assign cab_s  = stable_reg[PIN_W-2:MOD_W];
  assign mod_s  = stable_reg[MOD_W-1:0];

  // ---------------------------------------------------------------------
  // word assembly
  // ---------------------------------------------------------------------
  // words are rebuilt every cycle from live conditions; nothing latches R23
  usr_pkg::usr_sys1_t  sys1;
  usr_pkg::usr_sys2_t  sys2;
  usr_pkg::usr_sys3_t  sys3;
  usr_pkg::usr_mod_a_t mod_a;
  usr_pkg::usr_mod_b_t mod_b;

  always_comb begin
    sys1 = '0;
    sys2 = '0;
    sys3 = '0;
    // without a systems cabinet the three system words read zero R2
    if (cab_ok) begin
      sys1.board_link_ok      = cab_s.board_link_ok;          // R4
      sys1.xfmr_fuse_ok       = cab_s.xfmr_fuse_ok;           // R5
      sys1.supply_good        = cab_s.supply_good;            // R6
      sys1.fan_ok             = cab_s.fan_ok;                 // R7
      sys2.ss_fuse_ok         = cab_s.ss_fuse_ok;             // R8
      sys2.remote_contact     = cab_s.remote_contact;         // R9
      sys3.rotation_cw        = cab_s.bypass_rotation_cw;     // R10
      sys3.rotation_ccw       = cab_s.bypass_rotation_ccw;
      sys3.freq_lock          = cab_s.freq_lock;
      // sensed lags command by the synchroniser, so a short flag R11
      sys3.contactor_mismatch =
        mod_s.bypass_contactor_closed ^ bypass_contactor_cmd;  // R11
      sys3.comm_error         = ~&cab_s.board_link_ok;        // R12
      sys3.breaker_trip       = cab_s.bypass_breaker_overcurrent_trip; // R13
      sys3.zz_overload_trip   = cab_s.grounding_xfmr_overload_trip; // R14
      sys3.zz_breaker_trip    = cab_s.grounding_xfmr_breaker_trip;
    end
  end

  always_comb begin
    mod_a = '0;
    mod_b = '0;
    mod_a.contactor_closed   = {mod_s.bypass_contactor_closed,
                                mod_s.output_contactor_closed,
                                mod_s.input_contactor_closed}; // R15
    mod_a.board_link_ok      = mod_s.board_link_ok;           // R16
    mod_a.unload_timeout     = mod_s.unload_setpoint_timeout; // R17
    mod_a.low_speed_shutdown = mod_s.low_speed_shutdown;
    mod_a.rotor_master_on    = mod_s.rotor_master_ctrl_on;    // R18
    mod_a.ext_sync_cmd       = mod_s.ext_sync_cmd;
    mod_a.master_on          = mod_s.master_ctrl_on;
    mod_a.ss_contactor       = mod_s.static_switch_contactor_state; // R19
    mod_a.ss_fuse            = mod_s.static_switch_fuse_state;
    mod_b.discharging        = mod_s.discharging;             // R20
    mod_b.xfmr_fuse_ok       = mod_s.xfmr_fuse_ok;
    mod_b.supply_good        = mod_s.supply_good;             // R21
    mod_b.fan_ok             = mod_s.fan_ok;
  end

  // ---------------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------------
  // the map is tied to this revision number so software can check it R22
  assign logic_rev = `USR_LOGIC_REV;

  // writes are accepted and dropped; wdata and wr_stb steer nothing R23
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= `USR_RDATA_RST;
    end else if (rd_stb) begin
      if (addr == `USR_REG_SYS1) begin                         // R1
        rdata <= sys1;
      end else if (addr == `USR_REG_SYS2) begin
        rdata <= sys2;
      end else if (addr == `USR_REG_SYS3) begin
        rdata <= sys3;
      end else if (addr == `USR_REG_MOD_A) begin
        rdata <= mod_a;
      end else if (addr == `USR_REG_MOD_B) begin
        rdata <= mod_b;
      end else if (addr == `USR_REG_MOD_C) begin
        rdata <= mod_status_c;
      end else if (addr == `USR_REG_MOD_D) begin
        rdata <= mod_status_d;
      end else if (addr == `USR_REG_MOD_E) begin
        rdata <= mod_status_e;
      end else begin
        rdata <= `USR_RDATA_RST;
      end
    end else begin
      rdata <= `USR_RDATA_RST;
    end
  end

endmodule : usr_status_regs
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the status register group
// assumes usr_status_regs alone, 25 MHz clock, register port driven here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                   clk = 1'b0, rst = 1'b1, cab_present = 1'b1;
  logic                   wr_stb = 1'b0, rd_stb = 1'b0;
  logic                   bypass_contactor_cmd = 1'b0;
  usr_pkg::usr_cab_pins_t cab_pins = '0;
  usr_pkg::usr_mod_pins_t mod_pins = '0;
  logic [15:0]            mod_status_c = '0, mod_status_d = '0;
  logic [15:0]            mod_status_e = '0, addr = '0, wdata = '0;
  logic [15:0]            rdata, logic_rev;
  logic [63:0]            r;
  int                     miscompares = 0, cmp_count = 0;

  always #20 clk = ~clk;

  usr_status_regs u_usr_status_regs (
    .clk(clk), .rst(rst), .cab_present(cab_present), .cab_pins(cab_pins),
    .mod_pins(mod_pins), .bypass_contactor_cmd(bypass_contactor_cmd),
    .mod_status_c(mod_status_c), .mod_status_d(mod_status_d),
    .mod_status_e(mod_status_e), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .logic_rev(logic_rev));

  function automatic logic [15:0] expect_word(input logic [15:0] a);
    usr_pkg::usr_cab_pins_t c;
    usr_pkg::usr_mod_pins_t m;
    c = cab_pins;
    m = mod_pins;
    if (!cab_present && a < 16'h0161) begin
      return 16'h0000;
    end
    case (a)
      16'h015e: return {c.board_link_ok, c.xfmr_fuse_ok, 1'b0,
                        c.supply_good, 3'b000, c.fan_ok};
      16'h015f: return {c.ss_fuse_ok, 8'h00, c.remote_contact, 1'b0};
      16'h0160: return {c.bypass_rotation_cw, c.bypass_rotation_ccw,
                        c.freq_lock, 4'h0,
                        m.bypass_contactor_closed ^ bypass_contactor_cmd,
                        ~&c.board_link_ok, c.bypass_breaker_overcurrent_trip,
                        4'h0, c.grounding_xfmr_overload_trip,
                        c.grounding_xfmr_breaker_trip};
      16'h0161: return {m.bypass_contactor_closed, m.output_contactor_closed,
                        m.input_contactor_closed, m.board_link_ok,
                        m.unload_setpoint_timeout, m.low_speed_shutdown,
                        m.rotor_master_ctrl_on, m.ext_sync_cmd,
                        m.static_switch_contactor_state,
                        m.static_switch_fuse_state, m.master_ctrl_on};
      16'h0162: return {2'b00, m.discharging, 2'b00, m.xfmr_fuse_ok,
                        m.supply_good, m.fan_ok};
      16'h0163: return mod_status_c;
      16'h0164: return mod_status_d;
      16'h0165: return mod_status_e;
      default:  return 16'h0000;
    endcase
  endfunction : expect_word

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    cmp_count++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk

  // a write straight before each read: any write effect would show at once
  task automatic access(input logic [15:0] a);
    addr   <= a;
    wdata  <= 16'($urandom);
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, expect_word(a));
    @(posedge clk);
  endtask : access

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    void'($urandom(32'h3b47));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk(logic_rev, 16'h0001);
    // tests 0 to 2: all low, all high, all high without a cabinet
    for (int n = 0; n < 40; n++) begin
      r = {$urandom, $urandom};
      cab_present <= n != 2 && (n < 3 || r[5:4] != 2'b00);
      cab_pins <= n == 0 ? '0 : n < 3 ? '1 : r[$bits(cab_pins)-1:0];
      mod_pins <= n == 0 ? '0 : n < 3 ? '1 : r[63:64-$bits(mod_pins)];
      bypass_contactor_cmd <= r[40];
      mod_status_c <= r[15:0];
      mod_status_d <= r[31:16];
      mod_status_e <= r[47:32];
      repeat (8) @(posedge clk);
      for (int a = 16'h015d; a < 16'h0167; a++) begin
        access(16'(a));
      end
      $display("test %0d done", n);
    end
    // mid-run reset clears the stages: a read at the first edge after
    // release still sees zero, the pins show again four edges later
    mod_pins <= '1;
    repeat (8) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(rdata, 16'h0000);
    rst <= 1'b0;
    addr <= 16'h0161;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, 16'h0000);
    repeat (7) @(posedge clk);
    access(16'h0161);
    $display("reset test done");
    complete_run();
  end

  initial begin
    #(40 * 20000);
    miscompares++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire

// file: tb/usr_status_regs_assertions.sv
// checker for the status register group, bound to usr_status_regs
// assumes pins held still six cycles have passed the synchroniser
`timescale 1ns/1ps
`default_nettype none
module usr_status_checker (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   cab_present,
  input wire usr_pkg::usr_cab_pins_t cab_pins,
  input wire usr_pkg::usr_mod_pins_t mod_pins,
  input wire logic                   bypass_contactor_cmd,
  input wire logic [15:0]            mod_status_c,
  input wire logic [15:0]            addr,
  input wire logic                   rd_stb,
  input wire logic [15:0]            rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // copies taken at the read edge, so the answer is judged one cycle on
  usr_pkg::usr_cab_pins_t cab_reg;
  usr_pkg::usr_mod_pins_t mod_reg;
  logic                   cmd_reg;
  always_ff @(posedge clk) begin
    cab_reg <= cab_pins;
    mod_reg <= mod_pins;
    cmd_reg <= bypass_contactor_cmd;
  end
  // six quiet cycles: four sync edges plus margin for the agree step
  sequence settled_read(logic [15:0] a);
    ($stable(cab_pins) && $stable(mod_pins) && cab_present)[*6]
      ##0 (rd_stb && addr == a);
  endsequence
  a_idle_zero: assert property (
    !rd_stb |=> rdata == 16'h0000) else $error("rdata not zero when idle");
  a_unmapped_zero: assert property (
    rd_stb && (addr < 16'h015e || addr > 16'h0165) |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_word_c_pass: assert property (
    rd_stb && addr == 16'h0163 |=> rdata == $past(mod_status_c))
    else $error("word c not passed through");
  a_no_cabinet: assert property (
    (!cab_present)[*6] ##0 (rd_stb && addr < 16'h0161) |=> rdata == 16'h0000)
    else $error("system word set without cabinet");
  a_sys1_map: assert property (
    settled_read(16'h015e) |=> rdata == {cab_reg.board_link_ok,
      cab_reg.xfmr_fuse_ok, 1'b0, cab_reg.supply_good, 3'b000,
      cab_reg.fan_ok})
    else $error("system word one wrong");
  a_sys2_map: assert property (
    settled_read(16'h015f) |=> rdata == {cab_reg.ss_fuse_ok, 8'h00,
      cab_reg.remote_contact, 1'b0}) else $error("system word two wrong");
  a_sys3_flags: assert property (
    settled_read(16'h0160) |=> rdata == {cab_reg.bypass_rotation_cw,
      cab_reg.bypass_rotation_ccw, cab_reg.freq_lock, 4'h0,
      mod_reg.bypass_contactor_closed ^ cmd_reg, ~&cab_reg.board_link_ok,
      cab_reg.bypass_breaker_overcurrent_trip, 4'h0,
      cab_reg.grounding_xfmr_overload_trip,
      cab_reg.grounding_xfmr_breaker_trip})
    else $error("system word three wrong");
  a_mod_a_map: assert property (
    settled_read(16'h0161) |=> rdata == mod_reg[27:12])
    else $error("module word a wrong");
  a_mod_b_map: assert property (
    settled_read(16'h0162) |=> rdata == {2'b00, mod_reg.discharging, 2'b00,
      mod_reg.xfmr_fuse_ok, mod_reg.supply_good, mod_reg.fan_ok})
    else $error("module word b wrong");
endmodule : usr_status_checker
bind usr_status_regs usr_status_checker u_usr_status_checker (
  .clk(clk), .rst(rst), .cab_present(cab_present), .cab_pins(cab_pins),
  .mod_pins(mod_pins), .bypass_contactor_cmd(bypass_contactor_cmd),
  .mod_status_c(mod_status_c), .addr(addr), .rd_stb(rd_stb), .rdata(rdata));
`default_nettype wire
